// File: rtl/smprc_pkg.sv
package smprc_pkg;

   // ************************************************************
   // low-power mode codes (two codes left unused)
   // ************************************************************
   localparam logic [2:0] MODE_IDLE        = 3'h0;
   localparam logic [2:0] MODE_ADC_NR      = 3'h1;
   localparam logic [2:0] MODE_PDOWN       = 3'h2;
   localparam logic [2:0] MODE_PSAVE       = 3'h3;
   localparam logic [2:0] MODE_STANDBY     = 3'h6;
   localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

   // ************************************************************
   // register map, byte addresses, data in bits 7:0
   // ************************************************************
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_CMD       = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [3:0] PORT_FIRST    = 4'h1;
   localparam logic [3:0] PORT_LAST     = 4'h4;
   localparam logic [1:0] PSUB_OUT      = 2'h0;
   localparam logic [1:0] PSUB_DIR      = 2'h1;
   localparam logic [1:0] PSUB_PULL     = 2'h2;
   localparam logic [1:0] PSUB_PIN      = 2'h3;

   localparam int CTRL_SLEEP_EN_BIT = 0;
   localparam int CTRL_MODE_LSB     = 1;
   localparam int CTRL_ADC_USE_BIT  = 4;
   localparam int CMD_SLEEP_BIT     = 0;
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] PORT_RST  = 8'h00;

   // ************************************************************
   // test access pins on the third port
   // ************************************************************
   localparam int TEST_DI_BIT  = 5;
   localparam int TEST_MS_BIT  = 3;
   localparam int TEST_CK_BIT  = 2;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int         CLK_PERIOD_NS     = 10;
   localparam int         RST_MIN_PULSE_NS  = 1000;
   localparam logic [7:0] RST_MIN_CYCLES    =
      8'((RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [0:0] {
      ST_ACTIVE = 1'b0,
      ST_SLEEP  = 1'b1
   } smprc_state_t;

   typedef struct packed {
      logic cpu;
      logic io;
      logic adc;
      logic irq;
      logic async_tmr;
      logic osc;
   } smprc_dom_t;

   typedef struct packed {
      logic [2:0] ext_int;
      logic       async_tmr;
      logic       adc;
      logic       periph;
   } smprc_wake_t;

endpackage

// File: rtl/smprc_sleep_ctrl.sv
`timescale 1ns/10ps
module smprc_sleep_ctrl
   import smprc_pkg::*;
(
   input  wire logic                   clock_i,
   input  wire logic                   rstn_i,
   input  wire logic                   reset_pin_n_i,
   input  wire logic                   test_port_en_i,
   input  wire logic                   sleep_req_i,
   input  wire smprc_pkg::smprc_wake_t wake_i,
   input  wire logic [7:0]             avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire logic [31:0]            avs_writedata_i,
   input  wire logic [3:0]             avs_byteenable_i,
   output logic [31:0]                 avs_readdata_o,
   output logic                        avs_waitrequest_o,
   output smprc_pkg::smprc_dom_t       dom_en_o,
   output logic                        sys_reset_o,
   input  wire logic [7:0]             first_port_pins_i,
   output logic [7:0]                  first_port_pins_o,
   output logic [7:0]                  first_port_pins_oe_n_o,
   output logic [7:0]                  first_port_pull_o,
   input  wire logic [7:0]             second_port_pins_i,
   output logic [7:0]                  second_port_pins_o,
   output logic [7:0]                  second_port_pins_oe_n_o,
   output logic [7:0]                  second_port_pull_o,
   input  wire logic [7:0]             third_port_pins_i,
   output logic [7:0]                  third_port_pins_o,
   output logic [7:0]                  third_port_pins_oe_n_o,
   output logic [7:0]                  third_port_pull_o,
   input  wire logic [7:0]             fourth_port_pins_i,
   output logic [7:0]                  fourth_port_pins_o,
   output logic [7:0]                  fourth_port_pins_oe_n_o,
   output logic [7:0]                  fourth_port_pull_o
);
   import smprc_pkg::*;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic mode_valid(input logic [2:0] m);
      mode_valid = (m == MODE_IDLE) || (m == MODE_ADC_NR) ||
                   (m == MODE_PDOWN) || (m == MODE_PSAVE) ||
                   (m == MODE_STANDBY) || (m == MODE_EXT_STANDBY);
   endfunction

   // domains left running for a given state and mode
   function automatic smprc_dom_t dom_of(input smprc_state_t s, input logic [2:0] m);
      smprc_dom_t d;
      d = '{cpu: 1'b1, io: 1'b1, adc: 1'b1, irq: 1'b1, async_tmr: 1'b1, osc: 1'b1};
      if (s == ST_SLEEP) begin
         d.cpu = 1'b0;
         case (m)
            MODE_IDLE:        d = d;
            MODE_ADC_NR:      d.io = 1'b0;
            MODE_PDOWN:       d = '0;
            MODE_PSAVE:       d = '{async_tmr: 1'b1, default: 1'b0};
            MODE_STANDBY:     d = '{osc: 1'b1, default: 1'b0};
            MODE_EXT_STANDBY: d = '{osc: 1'b1, async_tmr: 1'b1, default: 1'b0};
            default:          d = d;
         endcase
      end
      dom_of = d;
   endfunction

   // wake sources each mode honours; the rest are asleep anyway
   function automatic logic wake_of(input logic [2:0] m, input smprc_wake_t w);
      logic ext;
      ext = |w.ext_int;
      case (m)
         MODE_IDLE:        wake_of = ext | w.async_tmr | w.adc | w.periph;
         MODE_ADC_NR:      wake_of = ext | w.async_tmr | w.adc;
         MODE_PSAVE,
         MODE_EXT_STANDBY: wake_of = ext | w.async_tmr;
         default:          wake_of = ext;
      endcase
   endfunction

   // ************************************************************
   // reset pin filter
   // ************************************************************
   logic [7:0] rst_cnt_reg;
   logic       pin_rst_reg;
   logic       sys_rst;

   // a glitch shorter than the minimum width is simply ignored
   always_ff @(posedge clock_i) begin
      if (!rstn_i || reset_pin_n_i) begin
         rst_cnt_reg <= 8'h00;
         pin_rst_reg <= 1'b0;
      end else if (rst_cnt_reg == RST_MIN_CYCLES - 8'h01) begin
         pin_rst_reg <= 1'b1;
      end else begin
         rst_cnt_reg <= rst_cnt_reg + 8'h01;
      end
   end

   assign sys_rst = !rstn_i || pin_rst_reg;

   always_ff @(posedge clock_i) begin
      sys_reset_o <= sys_rst;
   end

   // ************************************************************
   // bus decode
   // ************************************************************
   logic       req;
   logic       ack_reg;
   logic       wr_en;
   logic       port_hit;
   logic [1:0] port_idx;
   logic [1:0] port_sub;

   assign req      = avs_read_i || avs_write_i;
   assign wr_en    = avs_write_i && ack_reg == 1'b0 && avs_byteenable_i[0];
   assign port_hit = avs_address_i[7:4] >= PORT_FIRST && avs_address_i[7:4] <= PORT_LAST &&
                     avs_address_i[1:0] == 2'b00;
   assign port_idx = 2'(avs_address_i[7:4] - PORT_FIRST);
   assign port_sub = avs_address_i[3:2];

   // one wait cycle: answer sits one edge after the request is seen;
   // waitrequest has its own flop so the bus never sees a gate after the register
   always_ff @(posedge clock_i) begin
      if (sys_rst) begin
         ack_reg           <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end else begin
         ack_reg           <= req && !ack_reg;
         avs_waitrequest_o <= !(req && !ack_reg);
      end
   end

   // ************************************************************
   // control and sleep sequencing
   // ************************************************************
   logic [7:0]   ctrl_reg;
   smprc_state_t state_reg;
   smprc_state_t state_next;
   logic         sleep_cmd;

   always_ff @(posedge clock_i) begin
      if (sys_rst) begin
         ctrl_reg <= CTRL_RST;
      end else if (wr_en && avs_address_i == REG_CTRL) begin
         ctrl_reg[CTRL_SLEEP_EN_BIT] <= avs_writedata_i[CTRL_SLEEP_EN_BIT];
         ctrl_reg[CTRL_ADC_USE_BIT]  <= avs_writedata_i[CTRL_ADC_USE_BIT];
         // unused mode codes are refused, the old mode stays
         if (mode_valid(avs_writedata_i[CTRL_MODE_LSB +: 3])) begin
            ctrl_reg[CTRL_MODE_LSB +: 3] <= avs_writedata_i[CTRL_MODE_LSB +: 3];
         end
      end
   end

   assign sleep_cmd = sleep_req_i ||
                      (wr_en && avs_address_i == REG_CMD && avs_writedata_i[CMD_SLEEP_BIT]);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_ACTIVE: begin
            if (sleep_cmd && ctrl_reg[CTRL_SLEEP_EN_BIT]) begin
               state_next = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_of(ctrl_reg[CTRL_MODE_LSB +: 3], wake_i)) begin
               state_next = ST_ACTIVE;
            end
         end
         default: state_next = ST_ACTIVE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst) begin
         state_reg <= ST_ACTIVE;
         dom_en_o  <= '1;
      end else begin
         state_reg <= state_next;
         dom_en_o  <= dom_of(state_next, ctrl_reg[CTRL_MODE_LSB +: 3]);
      end
   end

   // ************************************************************
   // general ports
   // ************************************************************
   logic [3:0][7:0] out_reg;
   logic [3:0][7:0] dir_reg;
   logic [3:0][7:0] pull_reg;
   logic [3:0][7:0] pin_rd_reg;
   logic [3:0][7:0] pin_out_reg;
   logic [3:0][7:0] pin_oe_n_reg;
   logic [3:0][7:0] pin_pu_reg;
   logic [3:0][7:0] pins_in;
   logic [7:0]      test_pu_mask;

   assign pins_in = {fourth_port_pins_i, third_port_pins_i, second_port_pins_i, first_port_pins_i};

   always_ff @(posedge clock_i) begin
      if (sys_rst) begin
         out_reg  <= {4{PORT_RST}};
         dir_reg  <= {4{PORT_RST}};
         pull_reg <= {4{PORT_RST}};
      end else if (wr_en && port_hit) begin
         case (port_sub)
            PSUB_OUT:  out_reg[port_idx]  <= avs_writedata_i[7:0];
            PSUB_DIR:  dir_reg[port_idx]  <= avs_writedata_i[7:0];
            PSUB_PULL: pull_reg[port_idx] <= avs_writedata_i[7:0];
            default:   out_reg <= out_reg;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      pin_rd_reg <= pins_in;
   end

   always_comb begin
      test_pu_mask = 8'h00;
      if (test_port_en_i) begin
         test_pu_mask[TEST_DI_BIT] = 1'b1;
         test_pu_mask[TEST_MS_BIT] = 1'b1;
         test_pu_mask[TEST_CK_BIT] = 1'b1;
      end
   end

   // pull-ups only act on pins that are inputs, except the test pins on the third port; converter use wins over the first port
   always_ff @(posedge clock_i) begin
      if (sys_rst) begin
         pin_out_reg  <= '0;
         pin_oe_n_reg <= '1;
         pin_pu_reg   <= '0;
         pin_pu_reg[2] <= test_pu_mask;
      end else begin
         for (int p = 0; p < 4; p++) begin
            pin_out_reg[p]  <= out_reg[p];
            pin_oe_n_reg[p] <= ~dir_reg[p];
            pin_pu_reg[p]   <= pull_reg[p] & ~dir_reg[p];
         end
         pin_pu_reg[2] <= (pull_reg[2] & ~dir_reg[2]) | test_pu_mask;
         if (ctrl_reg[CTRL_ADC_USE_BIT]) begin
            pin_oe_n_reg[0] <= 8'hff;
            pin_pu_reg[0]   <= 8'h00;
         end
      end
   end

   assign first_port_pins_o       = pin_out_reg[0];
   assign first_port_pins_oe_n_o  = pin_oe_n_reg[0];
   assign first_port_pull_o       = pin_pu_reg[0];
   assign second_port_pins_o      = pin_out_reg[1];
   assign second_port_pins_oe_n_o = pin_oe_n_reg[1];
   assign second_port_pull_o      = pin_pu_reg[1];
   assign third_port_pins_o       = pin_out_reg[2];
   assign third_port_pins_oe_n_o  = pin_oe_n_reg[2];
   assign third_port_pull_o       = pin_pu_reg[2];
   assign fourth_port_pins_o      = pin_out_reg[3];
   assign fourth_port_pins_oe_n_o = pin_oe_n_reg[3];
   assign fourth_port_pull_o      = pin_pu_reg[3];

   // ************************************************************
   // read data
   // ************************************************************
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      if (avs_address_i == REG_CTRL) begin
         rd_mux = ctrl_reg;
      end else if (avs_address_i == REG_STATUS) begin
         rd_mux = {1'b0, dom_en_o, state_reg};
      end else if (port_hit) begin
         case (port_sub)
            PSUB_OUT:  rd_mux = out_reg[port_idx];
            PSUB_DIR:  rd_mux = dir_reg[port_idx];
            PSUB_PULL: rd_mux = pull_reg[port_idx];
            PSUB_PIN:  rd_mux = pin_rd_reg[port_idx];
            default:   rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && !ack_reg) begin
         avs_readdata_o <= {24'h00_0000, rd_mux};
      end
   end

endmodule

// File: testbench/smprc_sva.sv
`timescale 1ns/10ps
module smprc_sva
   import smprc_pkg::*;
(
   input wire logic                   clock_i,
   input wire logic                   rstn_i,
   input wire logic                   reset_pin_n_i,
   input wire logic                   test_port_en_i,
   input wire logic                   sleep_req_i,
   input wire smprc_pkg::smprc_wake_t wake_i,
   input wire logic                   avs_read_i,
   input wire logic                   avs_write_i,
   input wire logic [31:0]            avs_readdata_o,
   input wire logic                   avs_waitrequest_o,
   input wire smprc_pkg::smprc_dom_t  dom_en_o,
   input wire logic                   sys_reset_o,
   input wire logic [7:0]             first_port_pins_oe_n_o,
   input wire logic [7:0]             second_port_pins_oe_n_o,
   input wire logic [7:0]             third_port_pins_oe_n_o,
   input wire logic [7:0]             fourth_port_pins_oe_n_o,
   input wire logic [7:0]             second_port_pull_o,
   input wire logic [7:0]             third_port_pull_o,
   input wire logic [7:0]             fourth_port_pull_o
);
   // ************************************************************
   // bus, sleep and pin checks
   // ************************************************************
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic [7:0]  low_cnt;
   logic [31:0] oe_all;
   assign oe_all = {first_port_pins_oe_n_o, second_port_pins_oe_n_o, third_port_pins_oe_n_o, fourth_port_pins_oe_n_o};
   // saturates so a long hold never wraps back below the limit
   always_ff @(posedge clock_i) begin
      if (reset_pin_n_i) low_cnt <= 8'h00;
      else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
   end
   wait_ans_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus request not answered one cycle later");
   wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("answer held longer than one cycle");
   rd_upper_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   rst_float_a: assert property (disable iff (1'b0) !rstn_i |=> oe_all == 32'hffffffff && dom_en_o == 6'h3f)
      else $error("ports driven during reset");
   pin_rst_a: assert property (low_cnt >= 8'h66 |-> sys_reset_o && oe_all == 32'hffffffff)
      else $error("long reset pin pulse gave no reset");
   test_pull_a: assert property (disable iff (1'b0) test_port_en_i |=> (third_port_pull_o & 8'h2c) == 8'h2c)
      else $error("test pin pull-ups off while enabled");
   pull_out_a: assert property (((~second_port_pins_oe_n_o & second_port_pull_o) |
                                 (~fourth_port_pins_oe_n_o & fourth_port_pull_o)) == 8'h00)
      else $error("pull-up on a driven pin");
   sleep_pat_a: assert property (sleep_req_i && dom_en_o == 6'h3f && !sys_reset_o |=>
                                 dom_en_o inside {6'h3f, 6'h1f, 6'h0f, 6'h00, 6'h02, 6'h01, 6'h03})
      else $error("sleep entered an unknown domain pattern");
   ext_wake_a: assert property (wake_i.ext_int != 3'h0 && dom_en_o != 6'h3f |=> dom_en_o == 6'h3f)
      else $error("external interrupt did not wake");
   deep_hold_a: assert property (dom_en_o inside {6'h00, 6'h01} && wake_i.ext_int == 3'h0 && reset_pin_n_i |=>
                                 $stable(dom_en_o))
      else $error("deep sleep left without external wake");
endmodule

// File: testbench/smprc_board.sv
`timescale 1ns/10ps
module smprc_board
   import smprc_pkg::*;
#(
   parameter logic [7:0] EXT_LVL = 8'h18
)
(
   input  wire logic [31:0]           drv_i,
   input  wire logic [31:0]           oe_n_i,
   input  wire logic [31:0]           pull_i,
   input  wire logic                  clock_i,
   output logic [31:0]                pins_o,
   output logic                       reset_pin_n_o,
   output smprc_pkg::smprc_wake_t     wake_o
);
   // ************************************************************
   // pin levels: driven, pulled up, or the board's own level
   // ************************************************************
   assign pins_o = (~oe_n_i & drv_i) | (oe_n_i & (pull_i | {4{EXT_LVL}}));
   initial begin
      reset_pin_n_o = 1'b1;
      wake_o = '0;
   end
   task automatic pin(input logic lvl);
      @(posedge clock_i);
      reset_pin_n_o <= lvl;
   endtask
   // interrupt sources pulse for one cycle
   task automatic wake(input logic [5:0] w);
      @(posedge clock_i);
      wake_o <= w;
      @(posedge clock_i);
      wake_o <= '0;
   endtask
endmodule

// File: testbench/tb_sleep_mode_and_reset_pin_control.sv
`timescale 1ns/10ps
module tb_sleep_mode_and_reset_pin_control;
   import smprc_pkg::*;
   logic clock_i, rstn_i, test_port_en_i, sleep_req_i, avs_read_i, avs_write_i;
   logic        [7:0]  avs_address_i;
   logic        [31:0] avs_writedata_i, rd;
   logic        [3:0]  avs_byteenable_i;
   wire logic   [31:0] avs_readdata_o, drv, oen, pul, pins;
   wire logic          avs_waitrequest_o, sys_reset_o, reset_pin_n_i;
   smprc_wake_t        wake_i;
   smprc_dom_t         dom_en_o;
   int fails = 0, samples_checked = 0;
   logic [2:0] mcode [6] = '{MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE, MODE_STANDBY, MODE_EXT_STANDBY};
   logic [5:0] mpat  [6] = '{6'h1f, 6'h0f, 6'h00, 6'h02, 6'h01, 6'h03};
   // allowed non-external wake sources: bit0 periph, bit1 adc, bit2 timer
   logic [2:0] mwake [6] = '{3'h7, 3'h6, 3'h0, 3'h4, 3'h0, 3'h4};
   logic [7:0] pv;
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   smprc_sleep_ctrl dut_u (.clock_i, .rstn_i, .reset_pin_n_i, .test_port_en_i, .sleep_req_i, .wake_i, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .dom_en_o,
      .sys_reset_o, .first_port_pins_i(pins[31:24]), .first_port_pins_o(drv[31:24]),
      .first_port_pins_oe_n_o(oen[31:24]), .first_port_pull_o(pul[31:24]), .second_port_pins_i(pins[23:16]),
      .second_port_pins_o(drv[23:16]), .second_port_pins_oe_n_o(oen[23:16]), .second_port_pull_o(pul[23:16]),
      .third_port_pins_i(pins[15:8]), .third_port_pins_o(drv[15:8]), .third_port_pins_oe_n_o(oen[15:8]),
      .third_port_pull_o(pul[15:8]), .fourth_port_pins_i(pins[7:0]), .fourth_port_pins_o(drv[7:0]),
      .fourth_port_pins_oe_n_o(oen[7:0]), .fourth_port_pull_o(pul[7:0]));
   smprc_board board_u (.drv_i(drv), .oe_n_i(oen), .pull_i(pul), .clock_i, .pins_o(pins),
      .reset_pin_n_o(reset_pin_n_i), .wake_o(wake_i));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // holds the request until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'h1);
      chk(rd, {24'h0, exp});
   endtask
   task automatic sleep_via(input int k);
      if (k % 2 == 1) bus(1'b1, REG_CMD, 8'h01, 4'h1);
      else begin
         @(posedge clock_i);
         sleep_req_i <= 1'b1;
         @(posedge clock_i);
         sleep_req_i <= 1'b0;
      end
      @(negedge clock_i);
   endtask
   task automatic wake_chk(input logic [5:0] w, input logic [5:0] exp);
      board_u.wake(w);
      @(negedge clock_i);
      chk(32'(dom_en_o), 32'(exp));
   endtask
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      rstn_i = 1'b0;
      test_port_en_i = 1'b0;
      sleep_req_i = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 8'h00;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'h0;
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(negedge clock_i);
      chk(oen, 32'hffffffff);
      rchk(REG_CTRL, CTRL_RST);
      rchk(REG_STATUS, 8'h7e);
      rchk(8'h50, 8'h00);
      for (int m = 0; m < 6; m++) begin
         bus(1'b1, REG_CTRL, {4'h0, mcode[m], 1'b1}, 4'h1);
         for (int s = 0; s < 3; s++) begin
            sleep_via(s);
            chk(32'(dom_en_o), 32'(mpat[m]));
            if (s == 0) rchk(REG_STATUS, {1'b0, mpat[m], 1'b1});
            wake_chk(6'(1 << s), mwake[m][s] ? 6'h3f : mpat[m]);
            wake_chk(6'h08 << s, 6'h3f);
         end
      end
      // reserved mode codes keep the old mode, other bits still land
      bus(1'b1, REG_CTRL, 8'h08, 4'h1);
      rchk(REG_CTRL, 8'h0e);
      bus(1'b1, REG_CTRL, 8'h0b, 4'h1);
      rchk(REG_CTRL, 8'h0f);
      bus(1'b1, REG_CTRL, 8'h00, 4'h0);
      rchk(REG_CTRL, 8'h0f);
      bus(1'b1, REG_CTRL, 8'h00, 4'h1);
      sleep_via(0);
      chk(32'(dom_en_o), 32'h3f);
      for (int p = 1; p < 5; p++) begin
         pv = 8'h5a ^ 8'(p);
         bus(1'b1, 8'(p * 16), pv, 4'h1);
         bus(1'b1, 8'(p * 16 + 4), 8'h33, 4'h1);
         bus(1'b1, 8'(p * 16 + 8), 8'hc6, 4'h1);
         @(negedge clock_i);
         chk(32'(oen[(4 - p) * 8 +: 8]), 32'hcc);
         chk(32'(pul[(4 - p) * 8 +: 8]), 32'hc4);
         chk(32'(drv[(4 - p) * 8 +: 8]), 32'(pv));
         rchk(8'(p * 16 + 12), (pv & 8'h33) | 8'hcc);
      end
      bus(1'b1, REG_CTRL, 8'h10, 4'h1);
      @(negedge clock_i);
      chk(32'({oen[31:24], pul[31:24]}), 32'hff00);
      board_u.pin(1'b0);
      test_port_en_i <= 1'b1;
      repeat (105) @(posedge clock_i);
      @(negedge clock_i);
      chk({31'h0, sys_reset_o}, 32'h1);
      chk(oen, 32'hffffffff);
      chk(pul, 32'h00002c00);
      board_u.pin(1'b1);
      repeat (4) @(posedge clock_i);
      rchk(REG_CTRL, CTRL_RST);
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge clock_i);
      fails++;
      print_verdict;
   end
endmodule
bind smprc_sleep_ctrl smprc_sva chk_u (.clock_i, .rstn_i, .reset_pin_n_i, .test_port_en_i, .sleep_req_i, .wake_i,
   .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .dom_en_o, .sys_reset_o, .first_port_pins_oe_n_o,
   .second_port_pins_oe_n_o, .third_port_pins_oe_n_o, .fourth_port_pins_oe_n_o, .second_port_pull_o,
   .third_port_pull_o, .fourth_port_pull_o);
